// file: hdl/uic_cfg.svh
/*
 * register offsets, field positions and reset values of the usb interrupt
 * clear and mask block. assumes a 16-bit classic wishbone slave, byte
 * addressed, one aligned word per register.
 */
`ifndef UIC_CFG_SVH
`define UIC_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define UIC_OFS_SRC_STATUS_EP 6'h00
`define UIC_OFS_SRC_STATUS_CORE 6'h04
`define UIC_OFS_SRC_CLEAR_EP 6'h08
`define UIC_OFS_SRC_CLEAR_CORE 6'h0C
`define UIC_OFS_MASK_EP 6'h10
`define UIC_OFS_MASK_CORE 6'h14
`define UIC_OFS_MASK_SET_EP 6'h18
`define UIC_OFS_MASK_SET_CORE 6'h1C
`define UIC_OFS_MASK_CLR_EP 6'h20
`define UIC_OFS_MASK_CLR_CORE 6'h24
`define UIC_OFS_MASKED_EP 6'h28
`define UIC_OFS_MASKED_CORE 6'h2C

// ****************************************************************
// field layout and reset values
// ****************************************************************
`define UIC_EP_VALID 16'h1F1F
`define UIC_CORE_VALID 16'h01FF
`define UIC_SRC_RESET 16'h0000
`define UIC_MASK_RESET 16'h0000

`endif

// file: hdl/uic_pkg.sv
/*
 * types shared by the usb interrupt clear and mask block.
 * assumes uic_cfg.svh is included by the users of the constants.
 */
package uic_pkg;

    // ****************************************************************
    // register selector
    // ****************************************************************
    typedef enum logic [3:0] {
        SEL_SRC_EP,
        SEL_SRC_CORE,
        SEL_CLR_EP,
        SEL_CLR_CORE,
        SEL_MSK_EP,
        SEL_MSK_CORE,
        SEL_MSET_EP,
        SEL_MSET_CORE,
        SEL_MCLR_EP,
        SEL_MCLR_CORE,
        SEL_MASKED_EP,
        SEL_MASKED_CORE,
        SEL_NONE
    } uic_sel_t;

endpackage

// file: hdl/uic_bit_cell.sv
/*
 * one bit of the pending source and enable pair.
 * assumes all strobes are one-cycle pulses on sys_clk.
 */
module uic_bit_cell (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // event and software strobes
    input wire logic event_in,
    input wire logic src_clear,
    input wire logic mask_set,
    input wire logic mask_clear,
    // state
    output logic src_out,
    output logic mask_out
);

    typedef struct packed {
        logic src;
        logic mask;
    } uic_cell_t;

    uic_cell_t cur_ff;
    uic_cell_t nxt_cur;

    // next state: event wins over clear, set wins over clear for the mask
    always_comb begin
        nxt_cur = cur_ff;
        if (src_clear) begin
            nxt_cur.src = 1'b0;
        end
        if (event_in) begin
            nxt_cur.src = 1'b1;
        end
        if (mask_clear) begin
            nxt_cur.mask = 1'b0;
        end
        if (mask_set) begin
            nxt_cur.mask = 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign src_out = cur_ff.src;
    assign mask_out = cur_ff.mask;

endmodule

// file: hdl/uic_wb_decode.sv
/*
 * address decoder of the wishbone slave.
 * assumes byte addresses of six bits.
 */
`include "uic_cfg.svh"
module uic_wb_decode (
    // address
    input wire logic [5:0] adr,
    // selector
    output uic_pkg::uic_sel_t sel
);

    // offset to register selector
    always_comb begin
        case (adr)
            `UIC_OFS_SRC_STATUS_EP: sel = uic_pkg::SEL_SRC_EP;
            `UIC_OFS_SRC_STATUS_CORE: sel = uic_pkg::SEL_SRC_CORE;
            `UIC_OFS_SRC_CLEAR_EP: sel = uic_pkg::SEL_CLR_EP;
            `UIC_OFS_SRC_CLEAR_CORE: sel = uic_pkg::SEL_CLR_CORE;
            `UIC_OFS_MASK_EP: sel = uic_pkg::SEL_MSK_EP;
            `UIC_OFS_MASK_CORE: sel = uic_pkg::SEL_MSK_CORE;
            `UIC_OFS_MASK_SET_EP: sel = uic_pkg::SEL_MSET_EP;
            `UIC_OFS_MASK_SET_CORE: sel = uic_pkg::SEL_MSET_CORE;
            `UIC_OFS_MASK_CLR_EP: sel = uic_pkg::SEL_MCLR_EP;
            `UIC_OFS_MASK_CLR_CORE: sel = uic_pkg::SEL_MCLR_CORE;
            `UIC_OFS_MASKED_EP: sel = uic_pkg::SEL_MASKED_EP;
            `UIC_OFS_MASKED_CORE: sel = uic_pkg::SEL_MASKED_CORE;
            default: sel = uic_pkg::SEL_NONE;
        endcase
    end

endmodule

// file: hdl/uic_top.sv
/*
 * usb interrupt clear and mask logic: pending sources, enable masks,
 * set and clear aliases, masked status and one level interrupt.
 * assumes a classic wishbone master on sys_clk and event pulses from
 * the core on sys_clk.
 */
`include "uic_cfg.svh"
module uic_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [1:0] wb_sel_i,
    input wire logic [15:0] wb_dat_i,
    output logic [15:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // core event pulses, one bit per source position
    input wire logic [15:0] ep_event,
    input wire logic [15:0] core_event,
    // interrupt
    output logic irq
);

    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] dat;
    } uic_bus_t;

    uic_bus_t bus_ff;
    uic_bus_t nxt_bus;
    uic_pkg::uic_sel_t sel;
    logic [31:0] src_all;
    logic [31:0] mask_all;
    logic [31:0] valid_all;
    logic [31:0] event_all;
    logic [31:0] wr_src_clr;
    logic [31:0] wr_mask_set;
    logic [31:0] wr_mask_clr;
    logic [15:0] wdata;
    logic req;
    logic wr_go;

    // ****************************************************************
    // bus request
    // ****************************************************************
    uic_wb_decode u_dec (
        .adr(wb_adr_i),
        .sel(sel)
    );

    // new request only when no answer is standing
    assign req = wb_cyc_i & wb_stb_i & ~bus_ff.ack & ~bus_ff.err;
    assign wr_go = req & wb_we_i & (sel != uic_pkg::SEL_NONE);
    // byte lanes mask written data
    assign wdata = wb_dat_i & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // strobes per bit; zero bits and reserved bits do nothing
    always_comb begin
        wr_src_clr = '0;
        wr_mask_set = '0;
        wr_mask_clr = '0;
        if (wr_go) begin
            case (sel)
                uic_pkg::SEL_CLR_EP: wr_src_clr[15:0] = wdata;
                uic_pkg::SEL_CLR_CORE: wr_src_clr[31:16] = wdata;
                uic_pkg::SEL_MSET_EP: wr_mask_set[15:0] = wdata;
                uic_pkg::SEL_MSET_CORE: wr_mask_set[31:16] = wdata;
                uic_pkg::SEL_MCLR_EP: wr_mask_clr[15:0] = wdata;
                uic_pkg::SEL_MCLR_CORE: wr_mask_clr[31:16] = wdata;
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // source and mask cells
    // ****************************************************************
    // ep and core sources have separate valid masks, packed into one 32-bit layout with core in the upper half
    // the generate below needs the layout as an elaboration-time constant
    localparam logic [31:0] VALID_LAYOUT = {`UIC_CORE_VALID, `UIC_EP_VALID};
    assign valid_all = VALID_LAYOUT;
    assign event_all = {core_event, ep_event};

    // only valid positions get a cell; mask bit shares the source index
    generate
        for (genvar i = 0; i < 32; i++) begin : g_bit
            if (VALID_LAYOUT[i]) begin : g_cell
                uic_bit_cell u_cell (
                    .sys_clk(sys_clk),
                    .rst(rst),
                    .event_in(event_all[i]),
                    .src_clear(wr_src_clr[i]),
                    .mask_set(wr_mask_set[i]),
                    .mask_clear(wr_mask_clr[i]),
                    .src_out(src_all[i]),
                    .mask_out(mask_all[i])
                );
            end else begin : g_none
                assign src_all[i] = 1'b0;
                assign mask_all[i] = 1'b0;
            end
        end
    endgenerate

    // ****************************************************************
    // read mux and answer
    // ****************************************************************
    // reads of aliases return live state; mask register ignores writes
    always_comb begin
        nxt_bus = '0;
        if (req) begin
            nxt_bus.ack = (sel != uic_pkg::SEL_NONE);
            nxt_bus.err = (sel == uic_pkg::SEL_NONE);
            case (sel)
                uic_pkg::SEL_SRC_EP: nxt_bus.dat = src_all[15:0];
                uic_pkg::SEL_SRC_CORE: nxt_bus.dat = src_all[31:16];
                uic_pkg::SEL_CLR_EP: nxt_bus.dat = src_all[15:0];
                uic_pkg::SEL_CLR_CORE: nxt_bus.dat = src_all[31:16];
                uic_pkg::SEL_MSK_EP: nxt_bus.dat = mask_all[15:0];
                uic_pkg::SEL_MSK_CORE: nxt_bus.dat = mask_all[31:16];
                uic_pkg::SEL_MSET_EP: nxt_bus.dat = mask_all[15:0];
                uic_pkg::SEL_MSET_CORE: nxt_bus.dat = mask_all[31:16];
                uic_pkg::SEL_MCLR_EP: nxt_bus.dat = mask_all[15:0];
                uic_pkg::SEL_MCLR_CORE: nxt_bus.dat = mask_all[31:16];
                uic_pkg::SEL_MASKED_EP: nxt_bus.dat = src_all[15:0] & mask_all[15:0];
                uic_pkg::SEL_MASKED_CORE: nxt_bus.dat = src_all[31:16] & mask_all[31:16];
                default: nxt_bus.dat = 16'h0000;
            endcase
        end
    end

    // answer register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_ff <= '0;
        end else begin
            bus_ff <= nxt_bus;
        end
    end

    assign wb_ack_o = bus_ff.ack;
    assign wb_err_o = bus_ff.err;
    assign wb_dat_o = bus_ff.dat;
    // level interrupt from masked sources only
    assign irq = |(src_all & mask_all);

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_clear_ep_works: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_go && sel == uic_pkg::SEL_CLR_EP && wdata[0] && !ep_event[0])
        |=> !src_all[0]) else $error("ep source not cleared");
    a_clear_tx_works: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_go && sel == uic_pkg::SEL_CLR_EP && wdata[4] && !ep_event[4])
        |=> !src_all[4]) else $error("tx source not cleared");
    a_clear_core_works: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_go && sel == uic_pkg::SEL_CLR_CORE && wdata[8] && !core_event[8])
        |=> !src_all[24]) else $error("core source not cleared");
    a_clear_reads_src: assert property (@(posedge sys_clk) disable iff (rst)
        (req && !wb_we_i && sel == uic_pkg::SEL_CLR_EP)
        |=> wb_ack_o && wb_dat_o == $past(src_all[15:0])) else $error("bad clear read");
    a_event_wins: assert property (@(posedge sys_clk) disable iff (rst)
        ep_event[9] |=> src_all[9]) else $error("event lost");
    a_mask_set_bit: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_go && sel == uic_pkg::SEL_MSET_CORE && wdata[0])
        |=> mask_all[16]) else $error("mask not set");
    a_mask_clr_bit: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_go && sel == uic_pkg::SEL_MCLR_EP && wdata[12] && !wr_mask_set[12])
        |=> !mask_all[12]) else $error("mask not cleared");
    a_mask_ro: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_go && (sel == uic_pkg::SEL_MSK_EP || sel == uic_pkg::SEL_MSK_CORE))
        |=> mask_all == $past(mask_all)) else $error("mask written directly");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (src_all & ~valid_all) == 32'h0 && (mask_all & ~valid_all) == 32'h0)
        else $error("reserved bit set");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
        (src_all[1] && mask_all[1]) |-> irq) else $error("irq missing");
    a_ack_drops: assert property (@(posedge sys_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o) else $error("ack held");

    c_irq_raised: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
    c_clear_write: cover property (@(posedge sys_clk) disable iff (rst)
        wr_go && sel == uic_pkg::SEL_CLR_CORE);
    c_mask_set: cover property (@(posedge sys_clk) disable iff (rst) |wr_mask_set);
    c_unmapped: cover property (@(posedge sys_clk) disable iff (rst) wb_err_o);

endmodule

// file: bench/uic_tb.sv
/*
 * self-checking bench of the usb interrupt clear and mask block.
 * assumes uic_top with a one-cycle registered wishbone answer, offsets
 * from uic_cfg.svh and a 100 MHz sys_clk.
 */
`include "uic_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // signals and counters
    // ****************************************************************
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [15:0] wb_dat_i = 16'h0000;
    logic [15:0] ep_event = 16'h0000;
    logic [15:0] core_event = 16'h0000;
    logic [15:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic irq;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    uic_top uic_top_inst (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(2'h3), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .ep_event(ep_event), .core_event(core_event), .irq(irq)
    );

    // ****************************************************************
    // clock, timeout and verdict
    // ****************************************************************
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // cuts a hang short after far more cycles than the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack or err is sampled high
    task automatic xfer(input logic we, input logic [5:0] adr, input logic [15:0] wdat,
                        output logic [15:0] rdat, output logic [15:0] err);
        @(posedge sys_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wdat;
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
        rdat = wb_dat_o;
        err = {15'h0000, wb_err_o};
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask

    task automatic wr(input logic [5:0] adr, input logic [15:0] wdat);
        logic [15:0] r;
        logic [15:0] e;
        xfer(1'h1, adr, wdat, r, e);
    endtask

    task automatic rd(input logic [5:0] adr, input logic [15:0] exp);
        logic [15:0] r;
        logic [15:0] e;
        xfer(1'h0, adr, 16'h0000, r, e);
        chk(r, exp);
        chk(e, 16'h0000);
    endtask

    task automatic pulse(input logic [15:0] ep, input logic [15:0] core);
        @(posedge sys_clk);
        ep_event <= ep;
        core_event <= core;
        @(posedge sys_clk);
        ep_event <= 16'h0000;
        core_event <= 16'h0000;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_and_refuse();
        logic [15:0] r;
        logic [15:0] e;
        for (int a = 0; a < 12; a++) begin
            rd(6'(a * 4), 16'h0000);
        end
        xfer(1'h1, 6'h30, 16'hFFFF, r, e);
        chk(e, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
    endtask

    // all event lines pulse; only documented positions may latch
    task automatic t_sources();
        pulse(16'hFFFF, 16'hFFFF);
        rd(`UIC_OFS_SRC_STATUS_EP, 16'h1F1F);
        rd(`UIC_OFS_SRC_STATUS_CORE, 16'h01FF);
        rd(`UIC_OFS_SRC_CLEAR_EP, 16'h1F1F);
        rd(`UIC_OFS_SRC_CLEAR_CORE, 16'h01FF);
        rd(`UIC_OFS_MASKED_EP, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        wr(`UIC_OFS_SRC_STATUS_EP, 16'h0000);
        rd(`UIC_OFS_SRC_STATUS_EP, 16'h1F1F);
    endtask

    // set and clear aliases, with direct writes to the mask refused
    task automatic t_masks();
        wr(`UIC_OFS_MASK_SET_EP, 16'hE101);
        wr(`UIC_OFS_MASK_SET_EP, 16'h0202);
        rd(`UIC_OFS_MASK_EP, 16'h0303);
        wr(`UIC_OFS_MASK_EP, 16'hFFFF);
        rd(`UIC_OFS_MASK_SET_EP, 16'h0303);
        rd(`UIC_OFS_MASKED_EP, 16'h0303);
        chk({15'h0000, irq}, 16'h0001);
        wr(`UIC_OFS_MASK_CLR_EP, 16'h0001);
        wr(`UIC_OFS_MASK_CLR_EP, 16'h0000);
        rd(`UIC_OFS_MASK_CLR_EP, 16'h0302);
        wr(`UIC_OFS_MASK_SET_CORE, 16'hFFFF);
        wr(`UIC_OFS_MASK_CLR_CORE, 16'h0100);
        rd(`UIC_OFS_MASK_CORE, 16'h00FF);
        rd(`UIC_OFS_MASKED_CORE, 16'h00FF);
        wr(`UIC_OFS_MASK_CLR_EP, 16'hFFFF);
        wr(`UIC_OFS_MASK_CLR_CORE, 16'hFFFF);
        chk({15'h0000, irq}, 16'h0000);
        rd(`UIC_OFS_SRC_STATUS_EP, 16'h1F1F);
    endtask

    // acknowledging one or several sources per write in each field
    task automatic t_clear();
        wr(`UIC_OFS_SRC_CLEAR_EP, 16'h1000);
        rd(`UIC_OFS_SRC_STATUS_EP, 16'h0F1F);
        wr(`UIC_OFS_SRC_CLEAR_EP, 16'h0011);
        rd(`UIC_OFS_SRC_CLEAR_EP, 16'h0F0E);
        wr(`UIC_OFS_SRC_CLEAR_CORE, 16'hFF01);
        rd(`UIC_OFS_SRC_STATUS_CORE, 16'h00FE);
        wr(`UIC_OFS_SRC_CLEAR_EP, 16'h0000);
        rd(`UIC_OFS_SRC_STATUS_EP, 16'h0F0E);
        wr(`UIC_OFS_MASK_SET_CORE, 16'h0002);
        chk({15'h0000, irq}, 16'h0001);
        wr(`UIC_OFS_SRC_CLEAR_CORE, 16'h0002);
        chk({15'h0000, irq}, 16'h0000);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'h0;
        t_reset_and_refuse();
        t_sources();
        t_masks();
        t_clear();
        conclude();
    end
endmodule
